// File: include/cdsc_pkg.sv
`default_nettype none
package cdsc_pkg;
	localparam int unsigned ADDR_W = 13;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned INSTR_BITS = 16;
	localparam logic [4:0] INSTR_LAST = 5'h0f;
	localparam logic [4:0] BYTE_LAST = 5'h07;

	localparam logic [ADDR_W-1:0] ADDR_OUTPUT_MODE = 13'h0014;
	localparam logic [ADDR_W-1:0] ADDR_SIG_LOW = 13'h0024;
	localparam logic [ADDR_W-1:0] ADDR_SIG_HIGH = 13'h0025;
	localparam logic [ADDR_W-1:0] ADDR_DITHER = 13'h0030;
	localparam logic [ADDR_W-1:0] ADDR_SYNC_CTRL = 13'h0100;

	localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
	localparam int unsigned BIT_MASTER_SYNC = 0;
	localparam int unsigned BIT_DIV_SYNC_EN = 1;
	localparam int unsigned BIT_NEXT_SYNC_ONLY = 2;
	localparam logic [DATA_W-1:0] SYNC_CTRL_MASK = 8'h07;
	localparam int unsigned BIT_DITHER_EN = 4;
	localparam int unsigned BIT_OUTPUT_LVDS = 6;
	localparam int unsigned BIT_INSTR_READ = 15;

	localparam int unsigned NPIN = 5;
	localparam int unsigned PIN_CSB = 0;
	localparam int unsigned PIN_SCLK = 1;
	localparam int unsigned PIN_SDIO = 2;
	localparam int unsigned PIN_SYNC = 3;
	localparam int unsigned PIN_STRAP = 4;
	localparam logic [1:0] STRAP_FILL = 2'h3;

	typedef struct packed {
		logic strap;
		logic sync;
		logic sdio;
		logic sclk;
		logic csb_b;
	} cdsc_pins_s;

	typedef enum logic [1:0] {
		CDSC_IDLE  = 2'b00,
		CDSC_INSTR = 2'b01,
		CDSC_DATA  = 2'b10
	} cdsc_spi_e;
endpackage
`default_nettype wire

// File: rtl/cdsc_divider.sv
`timescale 1ns/10ps
`default_nettype none
module cdsc_divider (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [2:0] ratio,
	input  wire logic       phase_reset,
	output logic            div_clk_q,
	output logic            div_tick_q
);
	logic [2:0] cnt_q;
	logic [2:0] cnt_d;

	always_comb begin
		if (phase_reset) begin
			cnt_d = 3'h0;
		end else if (cnt_q >= ratio) begin
			cnt_d = 3'h0;
		end else begin
			cnt_d = cnt_q + 3'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 3'h0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// divide-by-one keeps the level high; use the tick for that ratio
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			div_clk_q  <= 1'b0;
			div_tick_q <= 1'b0;
		end else begin
			div_clk_q  <= (cnt_d <= (ratio >> 1));
			div_tick_q <= (cnt_d == 3'h0);
		end
	end
endmodule
`default_nettype wire

// File: rtl/cdsc_top.sv
// Summary of operation
// - no sync action unless master enable set
// - pulses reach divider only with divider enable
// - both enables, no one-shot: sync every pulse
// - one-shot: sync first pulse, ignore later ones
// - one-shot clears divider enable after sync
// - strap pin picks CMOS or LVDS at power-up
// - register write can select LVDS over strap
`timescale 1ns/10ps
`default_nettype none
module cdsc_top (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        spi_csb_b,
	input  wire logic        spi_sclk,
	input  wire logic        spi_sdio_in,
	output logic             spi_sdio_out,
	output logic             spi_sdio_oe_b,
	input  wire logic        sync_in,
	input  wire logic        lvds_strap,
	input  wire logic [15:0] self_test_signature,
	input  wire logic [2:0]  div_ratio,
	output logic             div_clk,
	output logic             div_tick,
	output logic             div_phase_reset,
	output logic             lvds_mode,
	output logic             dither_en
);
	cdsc_pkg::cdsc_pins_s                   pins_raw;
	logic [cdsc_pkg::NPIN-1:0]              s1_q;
	logic [cdsc_pkg::NPIN-1:0]              s2_q;
	logic [cdsc_pkg::NPIN-1:0]              s3_q;
	logic [cdsc_pkg::NPIN-1:0]              f_q;
	logic [cdsc_pkg::NPIN-1:0]              f_prev_q;
	logic [cdsc_pkg::DATA_W-1:0]            sync_ctrl_q;
	logic [cdsc_pkg::DATA_W-1:0]            dither_q;
	logic [cdsc_pkg::DATA_W-1:0]            out_mode_q;
	logic [15:0]                            sig_q;
	logic                                   strap_mode_q;
	logic                                   strap_taken_q;
	logic [1:0]                             fill_q;
	cdsc_pkg::cdsc_spi_e                    state_q;
	logic [4:0]                             bit_q;
	logic [15:0]                            shift_q;
	logic [cdsc_pkg::DATA_W-1:0]            tx_q;
	logic [cdsc_pkg::ADDR_W-1:0]            addr_q;
	logic                                   read_q;
	logic                                   sclk_rise;
	logic                                   sclk_fall;
	logic                                   sync_rise;
	logic                                   accept;
	logic                                   wr_strobe;
	logic [cdsc_pkg::DATA_W-1:0]            wr_data;
	logic [cdsc_pkg::DATA_W-1:0]            rd_data;
	logic [cdsc_pkg::DATA_W-1:0]            rd_next;

	assign pins_raw = '{strap: lvds_strap, sync: sync_in, sdio: spi_sdio_in, sclk: spi_sclk, csb_b: spi_csb_b};

	// three stages per pin; the filtered level moves only when stages two and three agree
	genvar gi;
	generate
		for (gi = 0; gi < cdsc_pkg::NPIN; gi++) begin : g_pin
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					// chip select starts at its idle level so release does not fake a selection
					s1_q[gi]     <= (gi == cdsc_pkg::PIN_CSB);
					s2_q[gi]     <= (gi == cdsc_pkg::PIN_CSB);
					s3_q[gi]     <= (gi == cdsc_pkg::PIN_CSB);
					f_q[gi]      <= (gi == cdsc_pkg::PIN_CSB);
					f_prev_q[gi] <= (gi == cdsc_pkg::PIN_CSB);
				end else begin
					s1_q[gi] <= pins_raw[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					if (s2_q[gi] == s3_q[gi]) begin
						f_q[gi] <= s3_q[gi];
					end
					f_prev_q[gi] <= f_q[gi];
				end
			end
		end
	endgenerate

	assign sclk_rise = f_q[cdsc_pkg::PIN_SCLK] & ~f_prev_q[cdsc_pkg::PIN_SCLK];
	assign sclk_fall = ~f_q[cdsc_pkg::PIN_SCLK] & f_prev_q[cdsc_pkg::PIN_SCLK];
	assign sync_rise = f_q[cdsc_pkg::PIN_SYNC] & ~f_prev_q[cdsc_pkg::PIN_SYNC];

	// one-shot needs no extra state: clearing the divider enable blocks later pulses
	assign accept = sync_rise & sync_ctrl_q[cdsc_pkg::BIT_MASTER_SYNC]
		& sync_ctrl_q[cdsc_pkg::BIT_DIV_SYNC_EN];

	function automatic logic [cdsc_pkg::DATA_W-1:0] reg_read(input logic [cdsc_pkg::ADDR_W-1:0] a);
		case (a)
			cdsc_pkg::ADDR_OUTPUT_MODE: reg_read = out_mode_q;
			cdsc_pkg::ADDR_SIG_LOW:     reg_read = sig_q[7:0];
			cdsc_pkg::ADDR_SIG_HIGH:    reg_read = sig_q[15:8];
			cdsc_pkg::ADDR_DITHER:      reg_read = dither_q;
			cdsc_pkg::ADDR_SYNC_CTRL:   reg_read = sync_ctrl_q;
			default:                    reg_read = cdsc_pkg::RESET_BYTE;
		endcase
	endfunction

	assign rd_data = reg_read({shift_q[11:0], f_q[cdsc_pkg::PIN_SDIO]});
	assign rd_next = reg_read(addr_q + 13'h0001);
	assign wr_data = {shift_q[6:0], f_q[cdsc_pkg::PIN_SDIO]};
	assign wr_strobe = (state_q == cdsc_pkg::CDSC_DATA) & sclk_rise & (bit_q == cdsc_pkg::BYTE_LAST)
		& ~read_q & ~f_q[cdsc_pkg::PIN_CSB];

	// serial port: 16-bit instruction (read flag, length, address) then data bytes, address steps up
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= cdsc_pkg::CDSC_IDLE;
			bit_q   <= 5'h00;
			shift_q <= 16'h0000;
			tx_q    <= cdsc_pkg::RESET_BYTE;
			addr_q  <= 13'h0000;
			read_q  <= 1'b0;
		end else if (f_q[cdsc_pkg::PIN_CSB]) begin
			state_q <= cdsc_pkg::CDSC_IDLE;
			bit_q   <= 5'h00;
		end else begin
			case (state_q)
				cdsc_pkg::CDSC_IDLE: begin
					state_q <= cdsc_pkg::CDSC_INSTR;
					bit_q   <= 5'h00;
				end
				cdsc_pkg::CDSC_INSTR: begin
					if (sclk_rise) begin
						shift_q <= {shift_q[14:0], f_q[cdsc_pkg::PIN_SDIO]};
						bit_q   <= bit_q + 5'h01;
						if (bit_q == cdsc_pkg::INSTR_LAST) begin
							read_q  <= shift_q[cdsc_pkg::BIT_INSTR_READ-1];
							addr_q  <= {shift_q[11:0], f_q[cdsc_pkg::PIN_SDIO]};
							tx_q    <= rd_data;
							bit_q   <= 5'h00;
							state_q <= cdsc_pkg::CDSC_DATA;
						end
					end
				end
				cdsc_pkg::CDSC_DATA: begin
					if (sclk_rise) begin
						shift_q <= {shift_q[14:0], f_q[cdsc_pkg::PIN_SDIO]};
						bit_q   <= bit_q + 5'h01;
						if (bit_q == cdsc_pkg::BYTE_LAST) begin
							bit_q  <= 5'h00;
							addr_q <= addr_q + 13'h0001;
							tx_q   <= rd_next;
						end
					end else if (sclk_fall && bit_q != 5'h00) begin
						tx_q <= {tx_q[6:0], 1'b0};
					end
				end
				default: begin
					state_q <= cdsc_pkg::CDSC_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			spi_sdio_out  <= 1'b0;
			spi_sdio_oe_b <= 1'b1;
		end else begin
			spi_sdio_out  <= tx_q[7];
			spi_sdio_oe_b <= ~(read_q & (state_q == cdsc_pkg::CDSC_DATA) & ~f_q[cdsc_pkg::PIN_CSB]);
		end
	end

	// a write in the same cycle as the self-clear keeps the written value
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sync_ctrl_q <= cdsc_pkg::RESET_BYTE;
		end else if (wr_strobe && addr_q == cdsc_pkg::ADDR_SYNC_CTRL) begin
			sync_ctrl_q <= wr_data & cdsc_pkg::SYNC_CTRL_MASK;
		end else if (accept && sync_ctrl_q[cdsc_pkg::BIT_NEXT_SYNC_ONLY]) begin
			sync_ctrl_q[cdsc_pkg::BIT_DIV_SYNC_EN] <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			dither_q   <= cdsc_pkg::RESET_BYTE;
			out_mode_q <= cdsc_pkg::RESET_BYTE;
		end else if (wr_strobe) begin
			if (addr_q == cdsc_pkg::ADDR_DITHER) begin
				dither_q <= wr_data;
			end
			if (addr_q == cdsc_pkg::ADDR_OUTPUT_MODE) begin
				out_mode_q <= wr_data;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sig_q <= 16'h0000;
		end else begin
			sig_q <= self_test_signature;
		end
	end

	// the strap is caught once the filter chain has filled after reset release
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			fill_q        <= 2'h0;
			strap_taken_q <= 1'b0;
			strap_mode_q  <= 1'b0;
		end else if (!strap_taken_q) begin
			if (fill_q == cdsc_pkg::STRAP_FILL) begin
				// take the agreeing stages: the filtered level itself settles one edge later
				if (s2_q[cdsc_pkg::PIN_STRAP] == s3_q[cdsc_pkg::PIN_STRAP]) begin
					strap_mode_q  <= s3_q[cdsc_pkg::PIN_STRAP];
					strap_taken_q <= 1'b1;
				end
			end else begin
				fill_q <= fill_q + 2'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lvds_mode       <= 1'b0;
			dither_en       <= 1'b0;
			div_phase_reset <= 1'b0;
		end else begin
			lvds_mode       <= strap_mode_q | out_mode_q[cdsc_pkg::BIT_OUTPUT_LVDS];
			dither_en       <= dither_q[cdsc_pkg::BIT_DITHER_EN];
			div_phase_reset <= accept;
		end
	end

	cdsc_divider i_cdsc_divider (
		.clk         (clk),
		.rst_b       (rst_b),
		.ratio       (div_ratio),
		.phase_reset (accept),
		.div_clk_q   (div_clk),
		.div_tick_q  (div_tick)
	);
endmodule
`default_nettype wire

// File: bench/cdsc_top_props.sv
`timescale 1ns/10ps
`default_nettype none
module cdsc_top_props (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        spi_csb_b,
	input wire logic        spi_sclk,
	input wire logic        spi_sdio_in,
	input wire logic        spi_sdio_out,
	input wire logic        spi_sdio_oe_b,
	input wire logic        sync_in,
	input wire logic        lvds_strap,
	input wire logic [15:0] self_test_signature,
	input wire logic [2:0]  div_ratio,
	input wire logic        div_clk,
	input wire logic        div_tick,
	input wire logic        div_phase_reset,
	input wire logic        lvds_mode,
	input wire logic        dither_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	pulse_width_a: assert property (div_phase_reset |=> !div_phase_reset) else $error("phase pulse long");
	phase_align_a: assert property (div_phase_reset |-> div_tick && div_clk) else $error("divider not aligned");
	phase_cause_a: assert property (div_phase_reset |-> $past(sync_in, 3)) else $error("phase without sync");
	quiet_sync_a: assert property (!sync_in [*8] |=> !div_phase_reset) else $error("phase while quiet");
	strap_lvds_a: assert property (lvds_strap [*6] |=> lvds_mode) else $error("strap ignored");
	lvds_hold_a: assert property (spi_csb_b [*8] |=> $stable(lvds_mode)) else $error("mode moved idle");
	read_drive_a: assert property ($fell(spi_sdio_oe_b) |-> !spi_csb_b) else $error("drive unselected");
	idle_release_a: assert property (spi_csb_b [*8] |-> spi_sdio_oe_b) else $error("sdio held idle");
	cover property (div_phase_reset);
	cover property ($fell(spi_sdio_oe_b));
	cover property (lvds_mode && !lvds_strap);
endmodule
bind cdsc_top cdsc_top_props i_cdsc_top_props (.*);
`default_nettype wire

// File: bench/cdsc_sync_src.sv
`timescale 1ns/10ps
`default_nettype none
module cdsc_sync_src (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic fire,
	output logic     sync_out
);
	logic [3:0] cnt_q;
	// high 8 cycles then low 8: both well above the pin filter time
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 4'h0;
		end else if (fire && cnt_q == 4'h0) begin
			cnt_q <= 4'hf;
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
		end
	end
	assign sync_out = cnt_q[3];
endmodule
`default_nettype wire

// File: bench/cdsc_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module cdsc_top_bench;
	logic       clk, rst_b, csb, sclk, sdio, fire, strap;
	logic       sdo, oe_b, sync, dclk, dtick, dphase, lvds, dith;
	logic [7:0] rv;
	int         fails, comparisons, n_phase;
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	cdsc_sync_src i_cdsc_sync_src (.clk(clk), .rst_b(rst_b), .fire(fire), .sync_out(sync));
	cdsc_top i_cdsc_top (.clk(clk), .rst_b(rst_b), .spi_csb_b(csb), .spi_sclk(sclk), .spi_sdio_in(sdio),
		.spi_sdio_out(sdo), .spi_sdio_oe_b(oe_b), .sync_in(sync), .lvds_strap(strap),
		.self_test_signature(16'h5aa5), .div_ratio(3'h3), .div_clk(dclk), .div_tick(dtick),
		.div_phase_reset(dphase), .lvds_mode(lvds), .dither_en(dith));
	always @(posedge clk) if (dphase === 1'b1) n_phase++;
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// half periods of 4 clk leave margin over the 3-flop pin filter
	task automatic spi(input logic rd, input logic [12:0] a, input logic [7:0] wd);
		logic [23:0] w;
		w = {rd, 2'h0, a, wd};
		csb = 1'b0;
		tick(4);
		for (int i = 23; i >= 0; i--) begin
			sdio = w[i];
			tick(4);
			if (i == 7 && rd) chk("sdio_oe_b", {7'h0, oe_b}, 8'h00);
			sclk = 1'b1;
			tick(4);
			// read data moves a few clocks after the filtered fall, so take it late in the high phase
			if (i < 8) rv[i] = sdo;
			sclk = 1'b0;
		end
		tick(4);
		csb = 1'b1;
		tick(8);
	endtask
	task automatic rdc(input logic [12:0] a, input logic [7:0] exp, input string name);
		spi(1'b1, a, 8'h00);
		chk(name, rv, exp);
	endtask
	task automatic pulse(input int exp);
		int n0;
		n0 = n_phase;
		fire = 1'b1;
		tick(1);
		fire = 1'b0;
		tick(20);
		chk("phase_resets", 8'(n_phase - n0), 8'(exp));
	endtask
	task automatic reset(input logic s);
		rst_b = 1'b0;
		strap = s;
		tick(4);
		rst_b = 1'b1;
		tick(8);
	endtask
	task automatic t_regs;
		rdc(13'h030, 8'h00, "dither_reset");
		rdc(13'h100, 8'h00, "sync_reset");
		rdc(13'h024, 8'ha5, "sig_low");
		rdc(13'h025, 8'h5a, "sig_high");
		spi(1'b0, 13'h024, 8'hff);
		rdc(13'h024, 8'ha5, "sig_low_ro");
		rdc(13'h1ff, 8'h00, "unmapped");
		spi(1'b0, 13'h030, 8'h10);
		chk("dither_en", {7'h0, dith}, 8'h01);
		spi(1'b0, 13'h100, 8'hff);
		rdc(13'h100, 8'h07, "sync_bits");
	endtask
	task automatic t_gate;
		for (int c = 0; c < 4; c++) begin
			spi(1'b0, 13'h100, 8'(c));
			pulse(c == 3 ? 1 : 0);
		end
		pulse(1);
	endtask
	task automatic t_oneshot;
		spi(1'b0, 13'h100, 8'h07);
		pulse(1);
		rdc(13'h100, 8'h05, "oneshot_clear");
		pulse(0);
		spi(1'b0, 13'h100, 8'h07);
		pulse(1);
		spi(1'b0, 13'h100, 8'h00);
	endtask
	task automatic t_lvds;
		chk("lvds_strap_low", {7'h0, lvds}, 8'h00);
		spi(1'b0, 13'h014, 8'h40);
		chk("lvds_by_reg", {7'h0, lvds}, 8'h01);
		rdc(13'h014, 8'h40, "out_mode_read");
		reset(1'b1);
		chk("lvds_strap_high", {7'h0, lvds}, 8'h01);
	endtask
	task automatic summarize;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		{rst_b, sclk, sdio, fire, strap} = 5'h00;
		csb = 1'b1;
		{fails, comparisons, n_phase} = '0;
		reset(1'b0);
		t_regs();
		t_gate();
		t_oneshot();
		t_lvds();
		summarize();
	end
	initial begin
		#160000;
		fails++;
		summarize();
	end
endmodule
`default_nettype wire
